/* File: rtl/ppc_pkg.sv */
// Purpose: Constants and types of the parallel port peripheral registers
// Assumes: APB slave, 32-bit data, one clock (pclk)
// Notes: One rule to a line below, tag first
// Function
// - Mode enable bits reset to disabled
// - Hardware drives link only with both hw enables
// - Latch host extensibility byte at event 4
// - Reverse transfer enable bit, reset clear
// - Reading interrupt status clears its flags
// - Four read-only status flags, reset zero
// - Four pin interrupt enable bits, edge or level
// - Four level bits select low or high
// - Pacing count sets clock periods between changes
// - Store forward ECP channel address, read-only
// - Direct pin control only with no mode
// - SelectIn rising edge flags negotiation start, except in ECP mode
// - Strobe falling edge flags transfer start, except in ECP mode
package ppc_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h9040011C;
   localparam logic [31:0] ADDR_MODE_ENABLE = 32'h90400120;
   localparam logic [31:0] ADDR_HOST_EXT_BYTE = 32'h90400124;
   localparam logic [31:0] ADDR_EXT_CONTROL = 32'h90400128;
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h9040012C;
   localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h90400130;
   localparam logic [31:0] ADDR_PIN_IRQ_MASK = 32'h90400134;
   localparam logic [31:0] ADDR_PIN_IRQ_CTRL = 32'h90400138;
   localparam logic [31:0] ADDR_PACING_COUNT = 32'h90400168;
   localparam logic [31:0] ADDR_FWD_CHAN_ADDR = 32'h90400174;

   // ==========================================================
   // Field positions
   localparam int MODE_ECP_BIT = 6;
   localparam int MODE_SPP_BIT = 5;
   localparam int MODE_HW_XFER_BIT = 4;
   localparam int MODE_HW_NEG_BIT = 2;
   localparam int EXT_REVERSE_BIT = 6;
   localparam int STS_PIN_SEL_BIT = 5;
   localparam int STS_CHAN_ADDR_BIT = 4;
   localparam int STS_NEG_START_BIT = 1;
   localparam int STS_XFER_START_BIT = 0;
   localparam int PIN_EDGE_LSB = 4;
   localparam int NUM_PINS = 4;

   // Writable masks and reset values
   localparam logic [31:0] MODE_ENABLE_MASK = 32'h00000074;
   localparam logic [31:0] EXT_CONTROL_MASK = 32'h00000040;
   localparam logic [31:0] IRQ_MASK = 32'h00000033;
   localparam logic [31:0] BYTE_MASK = 32'h000000FF;
   localparam logic [31:0] NIBBLE_MASK = 32'h0000000F;
   localparam logic [31:0] REG_RESET = 32'h00000000;

   // ==========================================================
   // Link inputs, bit 3 down to bit 0
   typedef struct packed {
      logic autofd_n;
      logic init_n;
      logic selectin_n;
      logic strobe_n;
   } ppc_pins_t;

   // Events from the transfer engine, same clock
   typedef struct packed {
      logic neg_event4;
      logic [7:0] ext_byte;
      logic chan_addr_valid;
      logic [7:0] chan_addr;
   } ppc_eng_evt_t;

   // Control levels handed to the link logic
   typedef struct packed {
      logic hw_link_drive;
      logic sw_pin_ctrl_en;
      logic reverse_xfer_en;
      logic ecp_en;
      logic spp_en;
   } ppc_ctrl_t;

endpackage : ppc_pkg

/* File: rtl/ppc_pace.sv */
// Purpose: Granularity pacing divider for automatic link modes
// Assumes: Single clock, count value stable while running
// Notes: Count of zero behaves as one period
`timescale 1ns/1ps
`default_nettype none
module ppc_pace #(
   parameter int CW = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic [CW-1:0] periods,
   // Pacing enable pulse
   output logic tick
);

   logic [CW-1:0] cnt_r;

   // ==========================================================
   // periods between ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else if (cnt_r + 1'b1 >= periods) begin
         cnt_r <= '0;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick <= 1'b0;
      end
   end

endmodule : ppc_pace
`default_nettype wire

/* File: rtl/ppc_regs.sv */
// Purpose: APB register bank of the parallel port peripheral side
// Assumes: Link pins are asynchronous; engine events on pclk
// Notes: Every access takes one wait state
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ppc_regs
   import ppc_pkg::*;
#(
   parameter int PACE_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link pins from the host
   input wire ppc_pins_t link_pins,
   // Transfer engine
   input wire ppc_eng_evt_t eng_evt,
   output ppc_ctrl_t ctrl,
   output logic pace_tick,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Decode helpers
   function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
      hit = (a == o);
   endfunction

   function automatic logic mapped(input logic [31:0] a);
      mapped = hit(a, ADDR_IRQ_ENABLE) || hit(a, ADDR_MODE_ENABLE) ||
               hit(a, ADDR_HOST_EXT_BYTE) || hit(a, ADDR_EXT_CONTROL) ||
               hit(a, ADDR_IRQ_STATUS) || hit(a, ADDR_IRQ_CLEAR) ||
               hit(a, ADDR_PIN_IRQ_MASK) || hit(a, ADDR_PIN_IRQ_CTRL) ||
               hit(a, ADDR_PACING_COUNT) || hit(a, ADDR_FWD_CHAN_ADDR);
   endfunction

   // ==========================================================
   // Storage
   logic [31:0] mode_enable_r;
   logic [31:0] host_ext_byte_r;
   logic [31:0] ext_control_r;
   logic [31:0] irq_status_r;
   logic [31:0] irq_enable_r;
   logic [31:0] pin_mask_r;
   logic [31:0] pin_ctrl_r;
   logic [31:0] pacing_r;
   logic [31:0] fwd_addr_r;

   logic access;
   logic commit;
   logic wr_commit;
   logic rd_commit;
   logic [31:0] rd_nxt;

   assign access = psel && penable;
   // Write effects and read clears land on the edge that sees pready
   assign commit = access && pready;
   assign wr_commit = commit && pwrite;
   assign rd_commit = commit && !pwrite;

   // ==========================================================
   // APB handshake: one wait state, data and error from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (access && !pready) begin
         pready <= 1'b1;
         pslverr <= !mapped(paddr);
         prdata <= pwrite ? 32'h00000000 : rd_nxt;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
   end

   always_comb begin
      rd_nxt = 32'h00000000;
      if (hit(paddr, ADDR_IRQ_ENABLE)) begin
         rd_nxt = irq_enable_r;
      end else if (hit(paddr, ADDR_MODE_ENABLE)) begin
         rd_nxt = mode_enable_r;
      end else if (hit(paddr, ADDR_HOST_EXT_BYTE)) begin
         rd_nxt = host_ext_byte_r;
      end else if (hit(paddr, ADDR_EXT_CONTROL)) begin
         rd_nxt = ext_control_r;
      end else if (hit(paddr, ADDR_IRQ_STATUS)) begin
         rd_nxt = irq_status_r;
      end else if (hit(paddr, ADDR_PIN_IRQ_MASK)) begin
         rd_nxt = pin_mask_r;
      end else if (hit(paddr, ADDR_PIN_IRQ_CTRL)) begin
         rd_nxt = pin_ctrl_r;
      end else if (hit(paddr, ADDR_PACING_COUNT)) begin
         rd_nxt = pacing_r;
      end else if (hit(paddr, ADDR_FWD_CHAN_ADDR)) begin
         rd_nxt = fwd_addr_r;
      end
   end

   // ==========================================================
   // Software configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_enable_r <= REG_RESET;
         ext_control_r <= REG_RESET;
         pin_mask_r <= REG_RESET;
         pin_ctrl_r <= REG_RESET;
         pacing_r <= REG_RESET;
         irq_enable_r <= REG_RESET;
      end else if (wr_commit) begin
         if (hit(paddr, ADDR_MODE_ENABLE)) begin
            mode_enable_r <= pwdata & MODE_ENABLE_MASK;
         end
         if (hit(paddr, ADDR_EXT_CONTROL)) begin
            ext_control_r <= pwdata & EXT_CONTROL_MASK;
         end
         if (hit(paddr, ADDR_PIN_IRQ_MASK)) begin
            pin_mask_r <= pwdata & NIBBLE_MASK;
         end
         if (hit(paddr, ADDR_PIN_IRQ_CTRL)) begin
            pin_ctrl_r <= pwdata & BYTE_MASK;
         end
         if (hit(paddr, ADDR_PACING_COUNT)) begin
            pacing_r <= pwdata & BYTE_MASK;
         end
         if (hit(paddr, ADDR_IRQ_ENABLE)) begin
            irq_enable_r <= pwdata & IRQ_MASK;
         end
      end
   end

   // ==========================================================
   // Values captured from the transfer engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_ext_byte_r <= REG_RESET;
      end else if (eng_evt.neg_event4) begin
         // latch at event 4, beats a software write
         host_ext_byte_r <= {24'h000000, eng_evt.ext_byte};
      end else if (wr_commit && hit(paddr, ADDR_HOST_EXT_BYTE)) begin
         host_ext_byte_r <= pwdata & BYTE_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_addr_r <= REG_RESET;
      end else if (eng_evt.chan_addr_valid) begin
         fwd_addr_r <= {24'h000000, eng_evt.chan_addr};
      end
   end

   // ==========================================================
   // Link pin synchronisers and edge detection
   logic [NUM_PINS-1:0] pin_s1_r;
   logic [NUM_PINS-1:0] pin_s2_r;
   logic [NUM_PINS-1:0] pin_s3_r;
   logic [NUM_PINS-1:0] pin_stable_r;
   logic [NUM_PINS-1:0] pin_rise;
   logic [NUM_PINS-1:0] pin_fall;
   logic [NUM_PINS-1:0] pin_hit;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         // A change counts once two later stages agree
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1_r[gi] <= 1'b1;
               pin_s2_r[gi] <= 1'b1;
               pin_s3_r[gi] <= 1'b1;
               pin_stable_r[gi] <= 1'b1;
            end else begin
               pin_s1_r[gi] <= link_pins[gi];
               pin_s2_r[gi] <= pin_s1_r[gi];
               pin_s3_r[gi] <= pin_s2_r[gi];
               if (pin_s2_r[gi] == pin_s3_r[gi]) begin
                  pin_stable_r[gi] <= pin_s3_r[gi];
               end
            end
         end

         assign pin_rise[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) &&
                               pin_s3_r[gi] && !pin_stable_r[gi];
         assign pin_fall[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) &&
                               !pin_s3_r[gi] && pin_stable_r[gi];
         // enabled pin; level select; edge bit set = rising
         assign pin_hit[gi] = pin_mask_r[gi] &&
            (pin_ctrl_r[PIN_EDGE_LSB + gi] ? pin_rise[gi] :
             (pin_stable_r[gi] == pin_ctrl_r[gi]));
      end
   endgenerate

   // ==========================================================
   // Interrupt status: set wins over any clear
   logic compat_mode;
   logic [31:0] sts_set;
   logic [31:0] sts_clr;

   // Compatibility mode is any mode other than ECP
   assign compat_mode = !mode_enable_r[MODE_ECP_BIT];

   always_comb begin
      sts_set = 32'h00000000;
      sts_set[STS_PIN_SEL_BIT] = |pin_hit;
      sts_set[STS_CHAN_ADDR_BIT] = eng_evt.chan_addr_valid;
      sts_set[STS_NEG_START_BIT] = compat_mode && pin_rise[1];
      sts_set[STS_XFER_START_BIT] = compat_mode && pin_fall[0];
   end

   always_comb begin
      sts_clr = 32'h00000000;
      if (rd_commit && hit(paddr, ADDR_IRQ_STATUS)) begin
         sts_clr = IRQ_MASK;
      end else if (wr_commit && hit(paddr, ADDR_IRQ_CLEAR)) begin
         sts_clr = pwdata & IRQ_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_r <= REG_RESET;
      end else begin
         irq_status_r <= ((irq_status_r & ~sts_clr) | sts_set) & IRQ_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_status_r & ~sts_clr) | sts_set) & irq_enable_r);
      end
   end

   // ==========================================================
   // Control levels to the link side
   logic hw_both;
   assign hw_both = mode_enable_r[MODE_HW_XFER_BIT] &&
                    mode_enable_r[MODE_HW_NEG_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= '0;
      end else begin
         // hardware drives link with both enables
         ctrl.hw_link_drive <= hw_both;
         // direct pin control only without modes
         ctrl.sw_pin_ctrl_en <= ~|(mode_enable_r & MODE_ENABLE_MASK);
         ctrl.reverse_xfer_en <= ext_control_r[EXT_REVERSE_BIT];
         ctrl.ecp_en <= mode_enable_r[MODE_ECP_BIT];
         ctrl.spp_en <= mode_enable_r[MODE_SPP_BIT];
      end
   end

   // ==========================================================
   // pacing of peripheral signal changes
   ppc_pace #(
      .CW(PACE_W)
   ) u_pace (
      .pclk(pclk),
      .presetn(presetn),
      .run(hw_both),
      .periods(pacing_r[PACE_W-1:0]),
      .tick(pace_tick)
   );

endmodule : ppc_regs
`default_nettype wire

/* File: test/ppc_regs_chk.sv */
// Purpose: Concurrent checks on the parallel port register bank
// Assumes: One clock, reset active low
// Notes: Bound onto every ppc_regs instance
`timescale 1ns/1ps
`default_nettype none
module ppc_regs_chk
   import ppc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Control and interrupt
   input wire ppc_ctrl_t ctrl,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd;
   assign rd = pready && !pwrite;
   // ==========================================================
   // Bus timing
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("ready late");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("stray error");
   // ==========================================================
   // Register contents, control levels and interrupt masking
   property p_mode; rd && paddr == ADDR_MODE_ENABLE |-> prdata[31:7] == 0
      && prdata[6] == ctrl.ecp_en && prdata[5] == ctrl.spp_en; endproperty
   a_mode: assert property (p_mode) else $error("mode bits");
   property p_drive; rd && paddr == ADDR_MODE_ENABLE
      |-> ctrl.hw_link_drive == (prdata[4] && prdata[2]); endproperty
   a_drive: assert property (p_drive) else $error("link drive");
   property p_rev; rd && paddr == ADDR_EXT_CONTROL
      |-> prdata == {25'h0, ctrl.reverse_xfer_en, 6'h0}; endproperty
   a_rev: assert property (p_rev) else $error("reverse bit");
   property p_sts; rd && paddr == ADDR_IRQ_STATUS
      |-> (prdata & ~IRQ_MASK) == 32'h0; endproperty
   a_sts: assert property (p_sts) else $error("status bits");
   property p_fwd; rd && paddr == ADDR_FWD_CHAN_ADDR
      |-> prdata[31:8] == 24'h0; endproperty
   a_fwd: assert property (p_fwd) else $error("fwd addr");
   property p_sw; ctrl.sw_pin_ctrl_en
      |-> !(ctrl.ecp_en || ctrl.spp_en || ctrl.hw_link_drive); endproperty
   a_sw: assert property (p_sw) else $error("pin control");
   property p_ien; pready && pwrite && paddr == ADDR_IRQ_ENABLE
      && pwdata == 32'h0 |-> ##2 !irq; endproperty
   a_ien: assert property (p_ien) else $error("irq unmasked");
endmodule // ppc_regs_chk

bind ppc_regs ppc_regs_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ctrl(ctrl), .irq(irq));
`default_nettype wire

/* File: test/ppc_host.sv */
// Purpose: Host side of the parallel link and its negotiation events
// Assumes: Tasks are called just after a rising edge
// Notes: Event fields are scrambled once their pulse is over
`timescale 1ns/1ps
`default_nettype none
module ppc_host
   import ppc_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Link pins and events
   output var ppc_pins_t pins,
   output var ppc_eng_evt_t evt
);
   // ==========================================================
   // Stimulus
   initial begin
      pins = 4'hF;
      evt = '0;
   end
   // Held six cycles so the synchroniser surely sees it
   task automatic set(input ppc_pins_t v);
      pins <= v;
      repeat (6) @(posedge pclk);
   endtask
   task automatic neg(input logic [7:0] b);
      evt <= {1'b1, b, 1'b0, 8'h00};
      @(posedge pclk);
      evt <= {1'b0, ~b, 1'b0, 8'h00};
      @(posedge pclk);
   endtask
   task automatic chan(input logic [7:0] a);
      evt <= {1'b0, 8'h00, 1'b1, a};
      @(posedge pclk);
      evt <= {1'b0, 8'h00, 1'b0, ~a};
      @(posedge pclk);
   endtask
endmodule // ppc_host
`default_nettype wire

/* File: test/ppc_regs_tb_top.sv */
// Purpose: Self-checking bench of the parallel port register bank
// Assumes: APB master tasks, host model on the link pins
// Notes: Runs in a few hundred cycles
`timescale 1ns/1ps
`default_nettype none
module ppc_regs_tb_top
   import ppc_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata, rv;
   logic pready, pslverr, pace_tick, irq, ev;
   ppc_pins_t pins;
   ppc_eng_evt_t evt;
   ppc_ctrl_t ctrl;
   int err_count = 0, num_checks = 0, n;
   logic [31:0] ra [9] = '{ADDR_IRQ_ENABLE, ADDR_MODE_ENABLE,
      ADDR_HOST_EXT_BYTE, ADDR_EXT_CONTROL, ADDR_IRQ_STATUS,
      ADDR_PIN_IRQ_MASK, ADDR_PIN_IRQ_CTRL, ADDR_PACING_COUNT,
      ADDR_FWD_CHAN_ADDR};
   logic [31:0] rm [9] = '{32'h33, 32'h74, 32'hFF, 32'h40, 32'h0,
      32'hF, 32'hFF, 32'hFF, 32'h0};

   ppc_regs #(.PACE_W(8)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_pins(pins), .eng_evt(evt), .ctrl(ctrl),
      .pace_tick(pace_tick), .irq(irq));
   ppc_host u_host (.pclk(pclk), .pins(pins), .evt(evt));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge pclk);
         k++;
      end
      rv = prdata;
      ev = pslverr;
      if (k >= 20) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [31:0] a, d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [31:0] a, exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rv, exp);
   endtask
   task automatic wait_tick(input int lim);
      n = 0;
      @(posedge pclk);
      while (pace_tick !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic wait_irq;
      for (int k = 0; k < 20 && irq !== 1'b1; k++) @(posedge pclk);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 32'h00000000;
      pwdata <= 32'h00000000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // Control levels are registered: first value after one more edge
      repeat (2) @(posedge pclk);
      chk("sw pin", ctrl.sw_pin_ctrl_en, 1);
      for (int i = 0; i < 9; i++) begin
         rdc(ra[i], 32'h0, "reset value");
         wr(ra[i], 32'hFFFFFFFF);
         rdc(ra[i], rm[i], "write mask");
      end
      $display("test registers done");
      chk("hw drive", ctrl.hw_link_drive, 1);
      chk("sw pin", ctrl.sw_pin_ctrl_en, 0);
      chk("ecp en", ctrl.ecp_en, 1);
      chk("spp en", ctrl.spp_en, 1);
      chk("reverse en", ctrl.reverse_xfer_en, 1);
      // 20 periods of 25 ns reach 500 ns
      wr(ADDR_PACING_COUNT, 32'h14);
      wait_tick(300);
      wait_tick(50);
      chk("pace period", n + 1, 20);
      wr(ADDR_MODE_ENABLE, 32'h10);
      @(posedge pclk);
      chk("hw drive", ctrl.hw_link_drive, 0);
      wr(ADDR_MODE_ENABLE, 32'h0);
      @(posedge pclk);
      chk("sw pin", ctrl.sw_pin_ctrl_en, 1);
      apb(1'b0, 32'h90400100, 32'h0);
      chk("slverr", ev, 1);
      $display("test modes done");
      wr(ADDR_PIN_IRQ_MASK, 32'h0);
      wr(ADDR_IRQ_ENABLE, 32'h0);
      u_host.set(4'hE);
      chk("irq", irq, 0);
      wr(ADDR_IRQ_ENABLE, 32'h33);
      wait_irq;
      chk("irq", irq, 1);
      rdc(ADDR_IRQ_STATUS, 32'h1, "status");
      rdc(ADDR_IRQ_STATUS, 32'h0, "status");
      chk("irq", irq, 0);
      u_host.set(4'hC);
      u_host.set(4'hE);
      wait_irq;
      rdc(ADDR_IRQ_STATUS, 32'h2, "status");
      wr(ADDR_PIN_IRQ_MASK, 32'h1);
      wr(ADDR_PIN_IRQ_CTRL, 32'hF0);
      u_host.set(4'hF);
      wait_irq;
      rdc(ADDR_IRQ_STATUS, 32'h20, "status");
      wr(ADDR_PIN_IRQ_CTRL, 32'h0);
      rdc(ADDR_IRQ_STATUS, 32'h0, "status");
      wr(ADDR_PIN_IRQ_CTRL, 32'h1);
      wait_irq;
      rdc(ADDR_IRQ_STATUS, 32'h20, "status");
      wr(ADDR_PIN_IRQ_MASK, 32'h0);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      rdc(ADDR_IRQ_STATUS, 32'h0, "status");
      $display("test interrupts done");
      u_host.neg(8'hA5);
      rdc(ADDR_HOST_EXT_BYTE, 32'hA5, "ext byte");
      u_host.chan(8'h3C);
      rdc(ADDR_FWD_CHAN_ADDR, 32'h3C, "fwd addr");
      rdc(ADDR_IRQ_STATUS, 32'h10, "status");
      // Write-one clear register, reads back as zero
      u_host.chan(8'hC3);
      rdc(ADDR_FWD_CHAN_ADDR, 32'hC3, "fwd addr");
      wr(ADDR_IRQ_CLEAR, 32'h1);
      rdc(ADDR_IRQ_CLEAR, 32'h0, "clear reg");
      wr(ADDR_IRQ_CLEAR, 32'h10);
      rdc(ADDR_IRQ_STATUS, 32'h0, "status");
      $display("test events done");
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      wrap_up();
   end
endmodule // ppc_regs_tb_top
`default_nettype wire
